/* analyzer_clock_reset_lowpower_defines.vh */
// Constants for the analyzer clock, reset and low-power control block.
//
// Contract
// - Active output is OR of raw bus select, raw self-test, memory busy, run bit.
// - Synchronized select and self-test form internal activity; it picks stop or deny.
// - Clock may stop only when idle: run clear, no access, no memory, no self-test.
// - Bus side and analyzer side are separate clock domains.
// - Reads only while stopped, except current-state values, readable any time.
// - Each functional reset clears only its domain; asserted async, released sync.
// - Bus-domain reset while running disables the analyzer.
// - Test-mode reset clears both domains asynchronously; held high otherwise.
// - Twelve observation groups, each 64 bits wide.
// - Eight external trigger inputs usable as trigger conditions.
// - Seven output actions, including system clock halt and cross-trigger.
// - Trace only while running; pre-trigger trace starts as the run bit sets.
`ifndef ANALYZER_CLOCK_RESET_LOWPOWER_DEFINES_VH
`define ANALYZER_CLOCK_RESET_LOWPOWER_DEFINES_VH

// ============================================================
// Observation interface sizes.
`define NUM_GROUPS        12
`define GROUP_WIDTH       64
`define GROUP_SEL_WIDTH   4
`define NUM_EXT_TRIGGERS  8
`define NUM_ACTIONS       7
`define TIMESTAMP_WIDTH   64
`define NUM_AUTH          4

// ============================================================
// Field positions and reset values.
`define ACTION_HALT_CLOCK 0
`define ACTIONS_RESET     7'h00
`define GROUP_RESET       64'h0000000000000000
`define TIMESTAMP_RESET   64'h0000000000000000

`endif

/* analyzer_clock_reset_lowpower.v */
// Clock, reset and Q-channel low-power control of the embedded logic analyzer.
`timescale 1ns/100ps
`default_nettype none
`include "analyzer_clock_reset_lowpower_defines.vh"

module analyzer_clock_reset_lowpower (
  input  wire                                       clk,
  input  wire                                       analyzer_domain_reset_n,
  input  wire                                       testmode_reset_n,
  input  wire                                       debug_domain_reset_n,
  input  wire                                       quiesce_request_n,
  output reg                                        qchan_accept_n,
  output reg                                        qchan_deny,
  output wire                                       qchan_active_out,
  input  wire                                       debug_bus_select,
  input  wire                                       selftest_request,
  input  wire                                       run_request,
  input  wire                                       pretrigger_action_reg,
  input  wire                                       trace_action,
  input  wire                                       trace_mem_access,
  input  wire [`NUM_AUTH-1:0]                       auth_allow,
  input  wire [`NUM_GROUPS*`GROUP_WIDTH-1:0]        signal_groups,
  input  wire [`NUM_GROUPS-1:0]                     group_sample_enable,
  input  wire [`GROUP_SEL_WIDTH-1:0]                group_select,
  input  wire [`NUM_EXT_TRIGGERS-1:0]               ext_trigger_in,
  input  wire [`NUM_EXT_TRIGGERS-1:0]               ext_trigger_mask,
  input  wire [`NUM_EXT_TRIGGERS-1:0]               ext_trigger_target,
  input  wire [`NUM_ACTIONS-1:0]                    action_request,
  input  wire [`TIMESTAMP_WIDTH-1:0]                timestamp_value_in,
  output reg                                        run_bit,
  output reg                                        trace_active,
  output reg                                        trace_mem_busy,
  output reg  [`GROUP_WIDTH-1:0]                    trace_payload,
  output reg  [`TIMESTAMP_WIDTH-1:0]                trace_timestamp,
  output reg                                        trace_capture,
  output reg                                        ext_trigger_match,
  output reg  [`NUM_ACTIONS-1:0]                    output_actions,
  output wire                                       halt_system_clock_out,
  output reg  [`NUM_AUTH-1:0]                       auth_state
);

  // ============================================================
  // Q-channel states.
  localparam [2:0] Q_RUN     = 3'h1;
  localparam [2:0] Q_STOPPED = 3'h2;
  localparam [2:0] Q_DENIED  = 3'h4;

  // ============================================================
  // Reset release.
  // Test-mode reset and the analyzer reset both clear this domain at once.
  wire       async_clear_n = analyzer_domain_reset_n & testmode_reset_n;
  reg  [1:0] rst_sync;
  wire       rst_n = rst_sync[1];

  // Assertion is asynchronous, release is taken through two stages.
  always @(posedge clk or negedge async_clear_n) begin
    if (!async_clear_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // ============================================================
  // Synchronisers for inputs from the bus-clock side.
  // Stage one is only read by stage two to keep metastability contained.
  reg [1:0] sel_sync;
  reg [1:0] mbist_sync;
  reg [1:0] qreq_sync;
  reg [1:0] run_sync;
  reg [1:0] dbgrst_sync;
  reg [`NUM_AUTH-1:0] auth_sync1;

  // The bus domain is a foreign clock here, so all its levels cross twice.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_sync    <= 2'h0;
      mbist_sync  <= 2'h0;
      qreq_sync   <= 2'h3;
      run_sync    <= 2'h0;
      dbgrst_sync <= 2'h3; // Idle level, so no false bus reset follows release.
      auth_sync1  <= 4'h0;
      auth_state  <= 4'h0;
    end else begin
      sel_sync    <= {sel_sync[0], debug_bus_select};
      mbist_sync  <= {mbist_sync[0], selftest_request};
      qreq_sync   <= {qreq_sync[0], quiesce_request_n};
      run_sync    <= {run_sync[0], run_request};
      dbgrst_sync <= {dbgrst_sync[0], debug_domain_reset_n};
      auth_sync1  <= auth_allow;
      auth_state  <= auth_sync1;
    end
  end

  // ============================================================
  // Run bit.
  // A bus-domain reset while running forces the run bit off, and it stays off
  // until software drops its run request, so a stale request cannot restart it.
  // The effective run state is a port of its own, readable at any time.
  reg disabled_by_reset;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_bit           <= 1'b0;
      disabled_by_reset <= 1'b0;
    end else begin
      if (!dbgrst_sync[1]) begin
        run_bit           <= 1'b0;
        disabled_by_reset <= run_sync[1];
      end else if (disabled_by_reset) begin
        run_bit           <= 1'b0;
        disabled_by_reset <= run_sync[1];
      end else begin
        run_bit           <= run_sync[1];
      end
    end
  end

  // ============================================================
  // Trace memory busy flag, one cycle per access.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_mem_busy <= 1'b0;
    end else begin
      trace_mem_busy <= trace_mem_access;
    end
  end

  // ============================================================
  // Activity and stop permission.
  // The raw pins feed the active output so the controller sees a bus access
  // before it has even crossed into this domain.
  assign qchan_active_out = debug_bus_select | selftest_request | trace_mem_busy | run_bit;

  wire internal_active = sel_sync[1] | mbist_sync[1];
  wire stop_allowed    = !run_bit && !sel_sync[1] && !trace_mem_busy && !mbist_sync[1];

  // ============================================================
  // Q-channel handshake.
  reg [2:0] q_state;
  reg [2:0] next_q_state;

  // Stop is granted only with no activity at all; anything else is denied.
  always @* begin
    next_q_state = q_state;
    case (q_state)
      Q_RUN: begin
        if (!qreq_sync[1]) begin
          if (internal_active || !stop_allowed) begin
            next_q_state = Q_DENIED;
          end else begin
            next_q_state = Q_STOPPED;
          end
        end
      end
      Q_STOPPED: begin
        if (qreq_sync[1]) begin
          next_q_state = Q_RUN;
        end
      end
      Q_DENIED: begin
        if (qreq_sync[1]) begin
          next_q_state = Q_RUN;
        end
      end
      default: begin
        next_q_state = Q_RUN;
      end
    endcase
  end

  // Answers are registered so they never glitch toward the controller.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_state        <= Q_RUN;
      qchan_accept_n <= 1'b1;
      qchan_deny     <= 1'b0;
    end else begin
      q_state        <= next_q_state;
      qchan_accept_n <= !(next_q_state == Q_STOPPED);
      qchan_deny     <= (next_q_state == Q_DENIED);
    end
  end

  // ============================================================
  // Observation sampling, one register per group.
  // Inputs are on this clock already, so no synchroniser is placed here.
  wire [`NUM_GROUPS*`GROUP_WIDTH-1:0] sampled_flat;
  genvar g;
  generate
    for (g = 0; g < `NUM_GROUPS; g = g + 1) begin : grp
      reg [`GROUP_WIDTH-1:0] sample;
      // A group holds its last value while its enable is low.
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sample <= `GROUP_RESET;
        end else if (group_sample_enable[g]) begin
          sample <= signal_groups[g*`GROUP_WIDTH +: `GROUP_WIDTH];
        end
      end
      assign sampled_flat[g*`GROUP_WIDTH +: `GROUP_WIDTH] = sample;
    end
  endgenerate

  // ============================================================
  // Trace, triggers and actions.
  // Selects past the last group read group zero rather than undefined data.
  wire [`GROUP_SEL_WIDTH-1:0] sel_index =
    (group_select < `NUM_GROUPS) ? group_select : {`GROUP_SEL_WIDTH{1'b0}};
  wire trace_on = run_bit & (pretrigger_action_reg | trace_action);

  // Trace and actions are dead from one cycle after the run bit goes low.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_active      <= 1'b0;
      trace_capture     <= 1'b0;
      trace_payload     <= `GROUP_RESET;
      trace_timestamp   <= `TIMESTAMP_RESET;
      ext_trigger_match <= 1'b0;
      output_actions    <= `ACTIONS_RESET;
    end else begin
      trace_active  <= trace_on;
      trace_capture <= trace_on;
      if (trace_on) begin
        trace_payload   <= sampled_flat[sel_index*`GROUP_WIDTH +: `GROUP_WIDTH];
        trace_timestamp <= timestamp_value_in;
      end
      ext_trigger_match <= run_bit &&
        (((ext_trigger_in ^ ext_trigger_target) & ext_trigger_mask) == 8'h00);
      output_actions <= run_bit ? action_request : `ACTIONS_RESET;
    end
  end

  assign halt_system_clock_out = output_actions[`ACTION_HALT_CLOCK];

endmodule
`default_nettype wire

/* analyzer_clock_reset_lowpower_props.sv */
// Concurrent checks on the ports of the analyzer clock, reset and low-power block.
`timescale 1ns/100ps
`default_nettype none
`include "analyzer_clock_reset_lowpower_defines.vh"
module analyzer_clock_reset_lowpower_props (
  input wire logic                          clk,
  input wire logic                          analyzer_domain_reset_n,
  input wire logic                          testmode_reset_n,
  input wire logic                          debug_domain_reset_n,
  input wire logic                          quiesce_request_n,
  input wire logic                          qchan_accept_n,
  input wire logic                          qchan_deny,
  input wire logic                          qchan_active_out,
  input wire logic                          debug_bus_select,
  input wire logic                          selftest_request,
  input wire logic                          pretrigger_action_reg,
  input wire logic                          trace_mem_access,
  input wire logic                          trace_mem_busy,
  input wire logic                          run_bit,
  input wire logic                          trace_active,
  input wire logic                          trace_capture,
  input wire logic [`TIMESTAMP_WIDTH-1:0]   trace_timestamp,
  input wire logic [`TIMESTAMP_WIDTH-1:0]   timestamp_value_in,
  input wire logic [`NUM_ACTIONS-1:0]       output_actions,
  input wire logic                          halt_system_clock_out,
  input wire logic                          ext_trigger_match
);
  // ============================================================
  // Everything lives on the analyzer clock; the analyzer or the test-mode reset mutes the checks, the bus reset does not.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!analyzer_domain_reset_n || !testmode_reset_n);
  a_active_or_sources: assert property (qchan_active_out == (debug_bus_select | selftest_request | trace_mem_busy | run_bit)) else $error("active output not the OR of its sources");
  a_busy_follows_access: assert property (trace_mem_access |=> trace_mem_busy) else $error("memory busy missed an access");
  a_answer_in_three: assert property ($fell(quiesce_request_n) |-> ##3 (!qchan_accept_n || qchan_deny)) else $error("no answer three edges after request");
  a_accept_when_idle: assert property ($fell(qchan_accept_n) |-> !$past(run_bit) && !qchan_deny) else $error("accepted while running");
  a_release_in_three: assert property ($rose(quiesce_request_n) |-> ##3 (qchan_accept_n && !qchan_deny)) else $error("answer not removed");
  a_accept_holds: assert property (!qchan_accept_n && !quiesce_request_n |=> !qchan_accept_n) else $error("accept dropped early");
  a_bus_reset_stops: assert property ($fell(debug_domain_reset_n) |-> ##3 !run_bit) else $error("bus reset left analyzer running");
  a_trace_needs_run: assert property (trace_active |-> $past(run_bit)) else $error("trace active while stopped");
  a_pretrigger_trace: assert property (run_bit && pretrigger_action_reg |=> trace_active) else $error("pre-trigger trace not started");
  a_stamp_captured: assert property (trace_capture |-> trace_timestamp == $past(timestamp_value_in)) else $error("timestamp not captured");
  a_actions_need_run: assert property (output_actions != 7'h00 |-> $past(run_bit) && halt_system_clock_out == output_actions[`ACTION_HALT_CLOCK]) else $error("action while stopped");
  a_trigger_needs_run: assert property (ext_trigger_match |-> $past(run_bit)) else $error("trigger match while stopped");
endmodule
bind analyzer_clock_reset_lowpower analyzer_clock_reset_lowpower_props u_props (.*);
`default_nettype wire

/* qchan_controller_model.sv */
// Behavioural clock controller on the far side of the Q-channel.
`timescale 1ns/100ps
`default_nettype none
module qchan_controller_model (
  input wire logic  clk,
  input wire logic  qchan_accept_n,
  input wire logic  qchan_deny,
  output var logic  quiesce_request_n
);
  initial quiesce_request_n = 1'b1;
  // ============================================================
  // One four-phase handshake; linger sets how slowly the controller releases.
  task automatic quiesce(input int linger, output logic denied, output int lat);
    lat = 0;
    @(negedge clk) quiesce_request_n = 1'b0;
    while (qchan_accept_n === 1'b1 && qchan_deny === 1'b0 && lat < 20) begin
      @(negedge clk);
      lat++;
    end
    denied = qchan_deny;
    // Request is held until the answer is in or 20 cycles pass, then for linger more cycles.
    repeat (linger) @(negedge clk);
    quiesce_request_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the analyzer clock, reset and low-power block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic          clk, analyzer_domain_reset_n, debug_domain_reset_n, debug_bus_select, selftest_request, run_request;
  logic          testmode_reset_n;
  wire  [3:0]    auth_state;
  logic          pretrigger_action_reg, trace_action, trace_mem_access, denied;
  logic [7:0]    ext_trigger_in, ext_trigger_target;
  logic [6:0]    action_request;
  logic [63:0]   timestamp_value_in;
  wire           quiesce_request_n, qchan_accept_n, qchan_deny, qchan_active_out;
  wire           run_bit, trace_active, trace_capture, ext_trigger_match, halt_system_clock_out;
  wire  [63:0]   trace_payload;
  wire  [6:0]    output_actions;
  int            fail_count, total_checks, lat;
  analyzer_clock_reset_lowpower i_dut (.clk(clk), .analyzer_domain_reset_n(analyzer_domain_reset_n), .testmode_reset_n(testmode_reset_n),
    .debug_domain_reset_n(debug_domain_reset_n), .quiesce_request_n(quiesce_request_n),
    .qchan_accept_n(qchan_accept_n), .qchan_deny(qchan_deny), .qchan_active_out(qchan_active_out),
    .debug_bus_select(debug_bus_select), .selftest_request(selftest_request), .run_request(run_request),
    .pretrigger_action_reg(pretrigger_action_reg), .trace_action(trace_action),
    .trace_mem_access(trace_mem_access), .auth_allow(4'hF),
    .signal_groups({704'h0, 64'h0123456789ABCDEF}),
    .group_sample_enable(12'hFFF), .group_select(4'h0), .ext_trigger_in(ext_trigger_in),
    .ext_trigger_mask(8'hFF), .ext_trigger_target(ext_trigger_target), .action_request(action_request),
    .timestamp_value_in(timestamp_value_in), .run_bit(run_bit), .trace_active(trace_active),
    .trace_mem_busy(), .trace_payload(trace_payload), .trace_timestamp(), .trace_capture(trace_capture),
    .ext_trigger_match(ext_trigger_match), .output_actions(output_actions),
    .halt_system_clock_out(halt_system_clock_out), .auth_state(auth_state));
  qchan_controller_model i_ctrl (.clk(clk), .qchan_accept_n(qchan_accept_n), .qchan_deny(qchan_deny),
    .quiesce_request_n(quiesce_request_n));
  // ============================================================
  // Shared helpers.
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ============================================================
  // Scenarios.
  task automatic t_active_sources;
    for (int i = 0; i < 3; i++) begin
      {selftest_request, debug_bus_select} = 2'(i);
      #1 check(qchan_active_out, i != 0);
      cyc(1);
    end
    // Both raw sources drop here, so only the memory busy flag can hold active up.
    {selftest_request, debug_bus_select} = 2'b00;
    trace_mem_access = 1'b1;
    cyc(1);
    trace_mem_access = 1'b0;
    check(qchan_active_out, 1'b1);
    cyc(1);
    check(qchan_active_out, 1'b0);
    check(auth_state, 4'hF);
  endtask
  // Bus select, then self-test, must turn a stop request into a refusal; with neither it is accepted.
  task automatic t_quiesce_choices;
    for (int i = 0; i < 3; i++) begin
      {selftest_request, debug_bus_select} = 2'(i);
      i_ctrl.quiesce(i, denied, lat);
      check(denied, i != 0);
      check(lat, 3);
    end
    {selftest_request, debug_bus_select} = 2'b00;
  endtask
  task automatic t_run_and_bus_reset;
    {run_request, pretrigger_action_reg, action_request} = {2'b11, 7'h41};
    lat = 0;
    while (run_bit !== 1'b1 && lat < 10) begin
      cyc(1);
      lat++;
    end
    check(lat, 3);
    cyc(2);
    check({trace_active, trace_capture, ext_trigger_match, halt_system_clock_out}, 4'hF);
    check(qchan_active_out, 1'b1);
    check(trace_payload, 64'h0123456789ABCDEF);
    check(output_actions, 7'h41);
    trace_action = 1'b1;
    cyc(2);
    check(trace_active, 1'b1);
    i_ctrl.quiesce(0, denied, lat);
    check(denied, 1'b1);
    debug_domain_reset_n = 1'b0;
    cyc(4);
    check({run_bit, trace_active, output_actions}, 9'h000);
    debug_domain_reset_n = 1'b1;
    cyc(4);
    check(run_bit, 1'b0);
    {run_request, trace_action} = 2'b00;
    cyc(4);
    i_ctrl.quiesce(2, denied, lat);
    check(denied, 1'b0);
    // Configuration changes only while stopped; trace then follows the current state alone.
    pretrigger_action_reg = 1'b0;
    {run_request, trace_action} = 2'b11;
    cyc(5);
    check({run_bit, trace_active, qchan_active_out}, 3'h7);
    // Test-mode reset clears a running analyzer at once, without waiting for an edge.
    testmode_reset_n = 1'b0;
    #1 check({run_bit, trace_active, output_actions}, 9'h000);
    cyc(2);
    testmode_reset_n = 1'b1;
    {run_request, trace_action} = 2'b00;
    cyc(6);
    // A bus reset after a clean stop must not block the next run.
    debug_domain_reset_n = 1'b0;
    cyc(4);
    debug_domain_reset_n = 1'b1;
    cyc(4);
    run_request = 1'b1;
    cyc(3);
    check(run_bit, 1'b1);
    run_request = 1'b0;
    cyc(4);
  endtask
  // ============================================================
  // Clock, stimulus sequence and watchdog.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) timestamp_value_in <= timestamp_value_in + 64'h1;
  initial begin
    {analyzer_domain_reset_n, testmode_reset_n, debug_domain_reset_n, debug_bus_select, selftest_request, run_request} = 6'b011000;
    {pretrigger_action_reg, trace_action, trace_mem_access, action_request} = 10'h000;
    {ext_trigger_in, ext_trigger_target, timestamp_value_in} = {16'hA5A5, 64'h0};
    cyc(4);
    analyzer_domain_reset_n = 1'b1;
    cyc(3);
    t_active_sources();
    t_quiesce_choices();
    t_run_and_bus_reset();
    conclude();
  end
  initial begin
    #100us;
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
